/* File: src/qec_defs.vh */
// register map, control field positions and reset values of the encoder channel
`ifndef QEC_DEFS_VH
`define QEC_DEFS_VH

// register indices; byte address is four times the index
`define QEC_IDX_LIMIT     4'h0
`define QEC_IDX_SNAPSHOT  4'h1
`define QEC_IDX_CONTROL   4'h3
`define QEC_IDX_LIVE      4'h5
// byte addresses
`define QEC_ADDR_LIMIT    6'h00
`define QEC_ADDR_SNAPSHOT 6'h04
`define QEC_ADDR_CONTROL  6'h0C
`define QEC_ADDR_LIVE     6'h14

// control field positions
`define QEC_QMODE_LO      14
`define QEC_QMODE_HI      15
`define QEC_CMODE_LO      16
`define QEC_CMODE_HI      17
`define QEC_ENABLE_BIT    18
`define QEC_SWAP_BIT      19
`define QEC_CTRL_MASK     32'h000FC000

// quadrature modes
`define QEC_QM_CLKDIR     2'h0
`define QEC_QM_SINGLE     2'h1
`define QEC_QM_DOUBLE     2'h2
`define QEC_QM_QUAD       2'h3

// counter modes
`define QEC_CM_FREE       2'h0
`define QEC_CM_RANGE      2'h1
`define QEC_CM_NORECYCLE  2'h2
`define QEC_CM_MODULO     2'h3

// reset values
`define QEC_CTRL_RESET    32'h00000000
`define QEC_LIMIT_RESET   24'h000000
`define QEC_COUNT_RESET   24'h000000

// counter width
`define QEC_COUNT_W       24

`endif

/* File: src/qec_pin_sync.v */
// three-stage synchroniser for the encoder pins with agreement filter
`timescale 1ns/1ps
`default_nettype none
module qec_pin_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         mclk_in,
  input  wire         sys_rst_in,
  // raw pins and filtered level
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // s1 feeds only s2; a new level counts once stages two and three agree
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s1_r      <= {W{1'b0}};
      s2_r      <= {W{1'b0}};
      s3_r      <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/qec_decoder.v */
// quadrature state machine producing up and down count pulses
`timescale 1ns/1ps
`default_nettype none
`include "qec_defs.vh"
module qec_decoder (
  // clock and reset
  input  wire       mclk_in,
  input  wire       sys_rst_in,
  // synchronised inputs and mode
  input  wire       a_in,
  input  wire       b_in,
  input  wire [1:0] qmode_in,
  // count pulses
  output reg        up_out,
  output reg        down_out
);
  reg a_prev_r;
  reg b_prev_r;
  wire fwd;
  wire rev;
  wire a_rise;

  // gray step: forward when new A equals old B inverted relation
  assign fwd    = (a_in ^ a_prev_r ^ b_in ^ b_prev_r) & (a_in ^ b_prev_r);
  assign rev    = (a_in ^ a_prev_r ^ b_in ^ b_prev_r) & ~(a_in ^ b_prev_r);
  assign a_rise = a_in & ~a_prev_r;

  // one pulse per qualifying transition; in modes 01, 10 and 11 double steps are ignored as noise
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      up_out   <= 1'b0;
      down_out <= 1'b0;
    end else begin
      a_prev_r <= a_in;
      b_prev_r <= b_in;
      up_out   <= 1'b0;
      down_out <= 1'b0;
      case (qmode_in)
        `QEC_QM_CLKDIR: begin
          up_out   <= a_rise & ~b_in;
          down_out <= a_rise & b_in;
        end
        `QEC_QM_SINGLE: begin
          // only the A rise with B low forward, or A fall with B low backward
          up_out   <= fwd & a_rise & ~b_in;
          down_out <= rev & ~a_in & a_prev_r & ~b_in;
        end
        `QEC_QM_DOUBLE: begin
          up_out   <= fwd & (a_in ^ a_prev_r);
          down_out <= rev & (a_in ^ a_prev_r);
        end
        default: begin
          up_out   <= fwd;
          down_out <= rev;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/qec_channel.v */
// encoder channel: avalon slave, control, limit, counter and snapshot latch
//
// Contract
// - mode 00: A rising edge counts, B level picks up or down.
// - mode 01: one count per four quadrature transitions.
// - mode 10: one count per two quadrature transitions.
// - mode 11: one count per quadrature transition.
// - quadrature mode lives in control bits 15:14, bit 15 the upper bit.
// - control bits 17:16 pick free, range-limit, non-recycle or modulo-N.
// - control bit 19 swaps A and B, reversing count direction in modes 01, 10 and 11.
// - control bit 18 enables counting; counts are dropped while it is low.
// - writing the snapshot address captures the counter; reads return the snapshot.
// - decoder pulses up on advance, down on retard; counter follows.
// - modulo wraps N to zero; limiting modes stop at the limit.
`timescale 1ns/1ps
`default_nettype none
`include "qec_defs.vh"
module qec_channel #(
  parameter CW = `QEC_COUNT_W
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  // encoder pins
  input  wire        enc_a_in,
  input  wire        enc_b_in,
  // avalon-mm slave
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output reg  [1:0]  avs_response_out
);
  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  reg  [31:0]   ctrl_r;
  reg  [CW-1:0] limit_r;
  reg  [CW-1:0] count_r;
  reg  [CW-1:0] count_nxt;
  reg  [CW-1:0] snap_r;
  reg           ack_r;
  wire [1:0]    pins_sync;
  wire          a_int;
  wire          b_int;
  wire          up_p;
  wire          down_p;
  wire [1:0]    qmode;
  wire [1:0]    cmode;
  wire          enable;
  wire          swap;
  wire          req;
  wire          take;
  wire [31:0]   limit_wr;

  // merge written bytes into an old word
  function [31:0] qec_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer k;
    begin
      qec_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          qec_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  assign qmode  = ctrl_r[`QEC_QMODE_HI:`QEC_QMODE_LO];
  assign cmode  = ctrl_r[`QEC_CMODE_HI:`QEC_CMODE_LO];
  assign enable = ctrl_r[`QEC_ENABLE_BIT];
  assign swap   = ctrl_r[`QEC_SWAP_BIT];

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  qec_pin_sync #(
    .W (2)
  ) u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     ({enc_b_in, enc_a_in}),
    .level_out  (pins_sync)
  );

  // swap after the synchroniser so both lines keep equal latency
  assign a_int = swap ? pins_sync[1] : pins_sync[0];
  assign b_int = swap ? pins_sync[0] : pins_sync[1];

  qec_decoder u_dec (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .a_in       (a_int),
    .b_in       (b_int),
    .qmode_in   (qmode),
    .up_out     (up_p),
    .down_out   (down_p)
  );

  // ----------------------------------------------------------------
  // counter next value
  // ----------------------------------------------------------------
  // limited modes trust software to have loaded the limit first
  always @* begin
    count_nxt = count_r;
    if (enable && (up_p ^ down_p)) begin
      case (cmode)
        `QEC_CM_FREE: begin
          count_nxt = up_p ? count_r + 1'b1 : count_r - 1'b1;
        end
        `QEC_CM_RANGE, `QEC_CM_NORECYCLE: begin
          // halt at either end of 0..limit rather than rolling
          if (up_p && count_r < limit_r) begin
            count_nxt = count_r + 1'b1;
          end else if (down_p && count_r != {CW{1'b0}}) begin
            count_nxt = count_r - 1'b1;
          end
        end
        default: begin
          if (up_p) begin
            count_nxt = (count_r >= limit_r) ? {CW{1'b0}} : count_r + 1'b1;
          end else begin
            count_nxt = (count_r == {CW{1'b0}}) ? limit_r : count_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // avalon handshake: one wait state on every access
  // ----------------------------------------------------------------
  assign req                 = avs_read_in | avs_write_in;
  assign take                = req & ack_r;
  assign avs_waitrequest_out = req & ~ack_r;

  // limit write merged at bus width, then cut to the counter width on purpose
  assign limit_wr = qec_merge({8'h00, limit_r}, avs_writedata_in, avs_byteenable_in);

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------------
  // register writes, counter and snapshot
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_r  <= `QEC_CTRL_RESET;
      limit_r <= `QEC_LIMIT_RESET;
      count_r <= `QEC_COUNT_RESET;
      snap_r  <= `QEC_COUNT_RESET;
    end else begin
      count_r <= count_nxt;
      if (take && avs_write_in) begin
        case (avs_address_in)
          `QEC_ADDR_LIMIT: begin
            limit_r <= limit_wr[CW-1:0];
          end
          `QEC_ADDR_CONTROL: begin
            ctrl_r <= qec_merge(ctrl_r, avs_writedata_in,
                                avs_byteenable_in) & `QEC_CTRL_MASK;
          end
          `QEC_ADDR_SNAPSHOT: begin
            snap_r <= count_r;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------
  // read data is registered in the wait cycle so it stands at the taking edge
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h00000000;
      avs_response_out <= 2'h0;
    end else if (req && !ack_r) begin
      avs_response_out <= 2'h0;
      case (avs_address_in)
        `QEC_ADDR_LIMIT:    avs_readdata_out <= {8'h00, limit_r};
        `QEC_ADDR_SNAPSHOT: avs_readdata_out <= {8'h00, snap_r};
        `QEC_ADDR_CONTROL:  avs_readdata_out <= ctrl_r;
        `QEC_ADDR_LIVE:     avs_readdata_out <= {8'h00, count_r};
        default: begin
          avs_readdata_out <= 32'h00000000;
          avs_response_out <= 2'h2; // unmapped: slave error
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/qec_enc_model.sv */
// encoder model driving quadrature or clock/direction pins
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model (
  // clock
  input  wire logic mclk_in,
  // encoder pins
  output var  logic a_out,
  output var  logic b_out
);
  logic [1:0] ph = 2'h0;
  initial begin
    a_out = 1'b0;
    b_out = 1'b0;
  end
  // ten cycles per state, above the four the synchroniser and pin filter take to pass a level
  task automatic hold();
    repeat (10) @(posedge mclk_in);
  endtask
  // one gray step; up means a leads b
  task automatic step(input logic up);
    @(posedge mclk_in);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    a_out <= ^ph;
    b_out <= ph[1];
    hold();
  endtask
  // direction settles first so the a edge never meets a b change
  task automatic pulse(input logic dn);
    @(posedge mclk_in);
    b_out <= dn;
    hold();
    a_out <= 1'b1;
    hold();
    a_out <= 1'b0;
    hold();
  endtask
endmodule
`default_nettype wire

/* File: testbench/qec_channel_sva.sv */
// assertions on the encoder channel register port
`timescale 1ns/1ps
`default_nettype none
module qec_channel_sva (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  // avalon-mm slave
  input wire logic [5:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic        req;
  logic        rd_t;
  logic        wr_t;
  logic        mapped;
  logic [31:0] ctl_r;
  logic [31:0] snap_r;
  logic        snap_ok_r;
  logic [31:0] be_m;
  assign be_m   = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign req    = avs_read_in | avs_write_in;
  assign rd_t   = avs_read_in & ~avs_waitrequest_out;
  assign wr_t   = avs_write_in & ~avs_waitrequest_out;
  assign mapped = avs_address_in inside {6'h00, 6'h04, 6'h0C, 6'h14};
  // control shadow honours the byte lanes; snapshot is zero out of reset
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctl_r     <= 32'h00000000;
      snap_r    <= 32'h00000000;
      snap_ok_r <= 1'b1;
    end else begin
      if (wr_t && avs_address_in == 6'h0C)
        ctl_r <= ((ctl_r & ~be_m) | (avs_writedata_in & be_m)) & 32'h000FC000;
      if (wr_t && avs_address_in == 6'h04)
        snap_ok_r <= 1'b0;
      else if (rd_t && avs_address_in == 6'h04) begin
        snap_r    <= avs_readdata_out;
        snap_ok_r <= 1'b1;
      end
    end
  end
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("request taken without wait state");
  wait_once_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait state");
  rdata_hold_a: assert property (!req |=> $stable(avs_readdata_out))
    else $error("read data moved while idle");
  bad_addr_a: assert property (rd_t && !mapped |-> avs_response_out == 2'h2
    && avs_readdata_out == 32'h0) else $error("unmapped read not refused");
  good_addr_a: assert property ((rd_t || wr_t) && mapped |-> avs_response_out == 2'h0)
    else $error("mapped access refused");
  count_width_a: assert property (rd_t && mapped && avs_address_in != 6'h0C |->
    avs_readdata_out[31:24] == 8'h00) else $error("count wider than 24 bits");
  ctl_echo_a: assert property (rd_t && avs_address_in == 6'h0C |->
    avs_readdata_out == ctl_r) else $error("control readback wrong");
  snap_hold_a: assert property (rd_t && avs_address_in == 6'h04 && snap_ok_r |->
    avs_readdata_out == snap_r) else $error("snapshot moved without write");
endmodule
bind qec_channel qec_channel_sva u_sva (.mclk_in, .sys_rst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .avs_response_out);
`default_nettype wire

/* File: testbench/tb_quadrature_encoder_counter_channel.sv */
// self-checking bench for the encoder channel
`timescale 1ns/1ps
`default_nettype none
`include "qec_defs.vh"
module tb_quadrature_encoder_counter_channel;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [5:0]  adr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata;
  logic        wt;
  logic [1:0]  resp;
  logic        enc_a;
  logic        enc_b;
  logic [31:0] got;
  int          mismatches = 0;
  int          n_checks = 0;
  always #12.5 mclk_in = ~mclk_in;
  qec_channel DUT (.mclk_in, .sys_rst_in, .enc_a_in(enc_a), .enc_b_in(enc_b),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .avs_response_out(resp));
  qec_enc_model enc (.mclk_in, .a_out(enc_a), .b_out(enc_b));
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one transfer, held until waitrequest is seen low; an edge passes after release
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wt !== 1'b0 && n < 20);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
    @(posedge mclk_in);
  endtask
  task automatic cfg(input logic sw, input logic en, input logic [1:0] cm, input logic [1:0] qm);
    bus(1'b1, `QEC_ADDR_CONTROL, {12'h0, sw, en, cm, qm, 14'h0});
  endtask
  task automatic st(input logic up, input int n);
    repeat (n) enc.step(up);
  endtask
  // capture then read back at once
  task automatic cnt(input logic [23:0] e);
    bus(1'b1, 6'h04, 32'hFFFFFFFF);
    bus(1'b0, 6'h04, 32'h0);
    chk(got, {8'h00, e});
  endtask
  task automatic t_reset();
    logic [5:0] ads[4] = '{6'h00, 6'h04, 6'h0C, 6'h14};
    foreach (ads[i]) begin
      bus(1'b0, ads[i], 32'h0);
      chk(got, 32'h0);
    end
    bus(1'b1, 6'h14, 32'h00000055);
    bus(1'b0, 6'h08, 32'h0);
    chk({got[31:2], resp}, 32'h2);
    bus(1'b0, 6'h14, 32'h0);
    chk(got, 32'h0);
  endtask
  task automatic t_modes();
    cfg(1'b0, 1'b0, 2'h0, 2'h3);
    st(1'b1, 4);
    cnt(24'h0);
    for (int q = 1; q < 4; q++) begin
      cfg(1'b0, 1'b1, 2'h0, q[1:0]);
      st(1'b1, 4);
      cnt(24'h1 << (q - 1));
      st(1'b0, 4);
      cnt(24'h0);
    end
  endtask
  task automatic t_limits();
    bus(1'b1, 6'h00, 32'h3);
    cfg(1'b0, 1'b1, 2'h3, 2'h3);
    st(1'b1, 5);
    cnt(24'h1);
    st(1'b0, 2);
    cnt(24'h3);
    bus(1'b1, 6'h00, 32'h5);
    cfg(1'b0, 1'b1, 2'h1, 2'h3);
    st(1'b1, 4);
    cnt(24'h5);
    cfg(1'b0, 1'b1, 2'h2, 2'h3);
    st(1'b0, 6);
    cnt(24'h0);
    cfg(1'b0, 1'b1, 2'h0, 2'h3);
    st(1'b0, 1);
    cnt(24'hFFFFFF);
    st(1'b1, 1);
    bus(1'b1, `QEC_ADDR_CONTROL, 32'hFFFFFFFF);
    bus(1'b0, `QEC_ADDR_CONTROL, 32'h0);
    chk(got, `QEC_CTRL_MASK);
    // only byte lane 1 written: bits 15:14 clear, 19:16 keep their ones
    be <= 4'h2;
    bus(1'b1, `QEC_ADDR_CONTROL, 32'h0);
    be <= 4'hF;
    bus(1'b0, `QEC_ADDR_CONTROL, 32'h0);
    chk(got, 32'h000F0000);
  endtask
  task automatic t_swap_snap();
    cfg(1'b1, 1'b1, 2'h0, 2'h3);
    st(1'b0, 4);
    cnt(24'h4);
    st(1'b0, 2);
    bus(1'b0, 6'h04, 32'h0);
    chk(got, 32'h4);
    bus(1'b0, 6'h14, 32'h0);
    chk(got, 32'h6);
  endtask
  task automatic t_clkdir();
    cfg(1'b0, 1'b1, 2'h0, 2'h0);
    repeat (3) enc.pulse(1'b0);
    enc.pulse(1'b1);
    cnt(24'h8);
  endtask
  // reset again in mid-run; every register must come back as zero
  task automatic t_rerun();
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    t_reset();
  endtask
  initial begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    t_reset();
    t_modes();
    t_limits();
    t_swap_snap();
    t_clkdir();
    t_rerun();
    tally_and_finish();
  end
endmodule
`default_nettype wire
